// ===== rtl/spims_port.sv
// Byte-wide SPI port, master or slave, with receive double buffering.
// Assumes all pin inputs, SCK included, are synchronous to clk_sys_i and
// that the slave SCK is slower than a quarter of the system clock.
`timescale 1ns/10ps
`default_nettype none
`include "spims_defs.svh"

// What this block does
// - Shift MSB first, both directions.
// - Full byte goes to buffer, set flags.
// - Next byte may shift before buffer read.
// - Write while busy ignored, collision flag set.
// - Collision flag clears only by software.
// - Buffer read clears buffer full flag.
// - Shift register reached only via buffer.
// - Control bits select role, clock, phases.
// - Enable bit hands pins to port.
// - Master transfer starts on buffer write.
// - SDO as input still shifts in.
// - Master rate: /4, /16, /64, timer/2.
// - Polarity bit sets SCK idle level.
// - Drive on one edge, latch opposite; master late sampling latches on the drive edge.
// - Edge select presents SDO before first edge.
// - Sample phase: middle or end.
// - Slave shifts per external clock pulse.
// - Low SS enables slave, drives SDO.
// - High SS tri-states SDO at once.
// - Module reset clears shift register.
// - Slave runs in low power, wakes.
// - Master pauses in sleep, resumes.
// - Master completion wakes when enabled.
// - Master mode codes pick clock source.
// - Device reset abandons transfer; enable not cleared.
module spims_port (
	input  wire logic                clk_sys_i,
	input  wire logic                rstn_i,
	input  wire spims_pkg::spims_cfg_s cfg_i,
	input  wire logic                buf_wr_i,
	input  wire logic [7:0]          buf_wdata_i,
	input  wire logic                buf_rd_i,
	input  wire logic                write_collision_flag_clr_i,
	input  wire logic                irq_clr_i,
	input  wire logic                irq_en_i,
	input  wire logic                sleep_i,
	input  wire logic                tmr2_pulse_i,
	input  wire logic                sdo_dir_in_i,
	input  wire logic                sck_i,
	input  wire logic                sdi_i,
	input  wire logic                ss_n_i,
	output logic                     sck_o,
	output logic                     sck_oe_o,
	output logic                     sdo_o,
	output logic                     sdo_oe_o,
	output logic [7:0]               rx_data_o,
	output logic [7:0]               ctrl_one_o,
	output logic [7:0]               status_o,
	output logic                     irq_flag_o,
	output logic                     wake_o
);
	import spims_pkg::*;

	// ****************************************
	// Decode of configuration
	// ****************************************

	logic         en;
	logic         is_master;
	logic         ss_ctl;
	logic         mod_rst;
	logic [5:0]   half_last;
	logic         use_tmr;

	// Mode codes below the slave codes are master modes.
	assign en        = cfg_i.en;
	assign is_master = cfg_i.mode < `SPIMS_MODE_SLV_SS;
	assign ss_ctl    = cfg_i.mode == `SPIMS_MODE_SLV_SS;
	assign use_tmr   = cfg_i.mode == `SPIMS_MODE_MTMR;
	// Disable or a high SS in select mode resets the shifter.
	assign mod_rst   = !en || (ss_ctl && ss_n_i);
	// Half period counts; the timer mode counts timer pulses instead.
	assign half_last = (cfg_i.mode == `SPIMS_MODE_MDIV64) ? 6'(`SPIMS_HALF64 - 1) :
	                   (cfg_i.mode == `SPIMS_MODE_MDIV16) ? 6'(`SPIMS_HALF16 - 1) :
	                   6'(`SPIMS_HALF4 - 1);

	// ****************************************
	// Registers
	// ****************************************

	spims_state_e state_reg;
	logic [7:0]   shreg_reg;
	logic [7:0]   buf_reg;
	logic [5:0]   half_cnt_reg;
	logic [4:0]   edge_reg;
	logic [2:0]   bits_reg;
	logic         sck_reg;
	logic         sck_prev_reg;
	logic         sdo_reg;
	logic         bf_reg;
	logic         irq_reg;
	logic         write_collision_flag_reg;
	logic         wake_reg;

	// ****************************************
	// Master edge timing
	// ****************************************

	logic         busy;
	logic         tick_m;
	logic         m_out;
	logic         m_samp;
	logic         m_done;
	logic         edge_odd;
	logic         wr_ok;
	logic         write_collision_flag_set;

	// A slave counts as busy once its first bit is latched.
	assign busy     = (state_reg == ST_SHIFT) || (bits_reg != 3'h0);
	assign wr_ok    = buf_wr_i && en && !busy;
	assign write_collision_flag_set = buf_wr_i && busy;
	// Sleep freezes the divider, so the byte resumes where it stopped.
	assign tick_m   = (state_reg == ST_SHIFT) && !sleep_i &&
	                  (use_tmr ? tmr2_pulse_i : (half_cnt_reg == half_last));
	assign edge_odd = edge_reg[0];
	// Output edges are the leading ones when edge select is clear.
	assign m_out    = tick_m && (edge_reg < `SPIMS_LAST_STEP) &&
	                  (edge_odd == cfg_i.cke);
	// Late sampling moves each sample to the next edge.
	assign m_samp   = tick_m && (cfg_i.input_sample_phase ?
	                  ((edge_reg != 5'h0) && (edge_odd == cfg_i.cke)) :
	                  ((edge_reg < `SPIMS_LAST_STEP) && (edge_odd != cfg_i.cke)));
	assign m_done   = tick_m && (edge_reg == `SPIMS_LAST_STEP);

	// ****************************************
	// Slave edge detection
	// ****************************************

	logic         sck_chg;
	logic         s_act;
	logic         s_lead;
	logic         s_trail;
	logic         s_out;
	logic         s_samp;
	logic         s_done;

	// A leading edge leaves the idle level set by the polarity bit.
	assign sck_chg = sck_i != sck_prev_reg;
	assign s_act   = !is_master && !mod_rst;
	assign s_lead  = sck_chg && (sck_prev_reg == cfg_i.clock_idle_polarity);
	assign s_trail = sck_chg && (sck_prev_reg != cfg_i.clock_idle_polarity);
	assign s_out   = s_act && (cfg_i.cke ? s_trail : s_lead);
	assign s_samp  = s_act && (cfg_i.cke ? s_lead : s_trail);
	assign s_done  = s_samp && (bits_reg == `SPIMS_LAST_BIT);

	// ****************************************
	// Shared shift path
	// ****************************************

	logic         samp;
	logic         outp;
	logic         done;
	logic [7:0]   shift_nx;
	logic [7:0]   done_byte;

	assign samp      = m_samp || s_samp;
	assign outp      = m_out || s_out;
	assign done      = m_done || s_done;
	assign shift_nx  = {shreg_reg[6:0], sdi_i};
	// The last sample can land on the completing step.
	assign done_byte = samp ? shift_nx : shreg_reg;

	// Master state; a device reset abandons the byte.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			state_reg <= ST_IDLE;
		end else if (mod_rst || m_done) begin
			state_reg <= ST_IDLE;
		end else if (wr_ok && is_master) begin
			state_reg <= ST_SHIFT;
		end
	end

	// Shift register: reset, load from buffer write, shift on sample.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			shreg_reg <= `SPIMS_BYTE_RST;
		end else if (mod_rst) begin
			shreg_reg <= `SPIMS_BYTE_RST;
		end else if (wr_ok) begin
			shreg_reg <= buf_wdata_i;
		end else if (samp) begin
			shreg_reg <= shift_nx;
		end
	end

	// Half period divider, restarted at each edge.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			half_cnt_reg <= 6'h0;
		end else if (state_reg != ST_SHIFT || tick_m) begin
			half_cnt_reg <= 6'h0;
		end else if (!sleep_i) begin
			half_cnt_reg <= half_cnt_reg + 6'h1;
		end
	end

	// Edge index within the byte.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			edge_reg <= 5'h0;
		end else if (wr_ok) begin
			edge_reg <= 5'h0;
		end else if (tick_m) begin
			edge_reg <= edge_reg + 5'h1;
		end
	end

	// Slave bit count.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bits_reg <= 3'h0;
		end else if (mod_rst || is_master) begin
			bits_reg <= 3'h0;
		end else if (s_samp) begin
			bits_reg <= bits_reg + 3'h1;
		end
	end

	// SCK resets low, then rests at the idle level whenever no byte is shifting.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_reg <= 1'b0;
		end else if (state_reg != ST_SHIFT) begin
			sck_reg <= cfg_i.clock_idle_polarity;
		end else if (tick_m && edge_reg < `SPIMS_LAST_STEP) begin
			sck_reg <= !sck_reg;
		end
	end

	// Previous SCK level for slave edge detection.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sck_prev_reg <= 1'b0;
		end else begin
			sck_prev_reg <= sck_i;
		end
	end

	// Data out: MSB ready at load, next bit on each output edge.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			sdo_reg <= 1'b0;
		end else if (mod_rst) begin
			sdo_reg <= 1'b0;
		end else if (wr_ok) begin
			sdo_reg <= buf_wdata_i[7];
		end else if (outp) begin
			sdo_reg <= samp ? shreg_reg[6] : shreg_reg[7];
		end
	end

	// Receive buffer; the shifter is free for the next byte at once.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			buf_reg <= `SPIMS_BYTE_RST;
		end else if (done) begin
			buf_reg <= done_byte;
		end
	end

	// Flags: a set in the same cycle as a clear wins.
	always_ff @(posedge clk_sys_i or negedge rstn_i) begin
		if (!rstn_i) begin
			bf_reg   <= 1'b0;
			irq_reg  <= 1'b0;
			write_collision_flag_reg <= 1'b0;
			wake_reg <= 1'b0;
		end else begin
			bf_reg   <= done || (bf_reg && !buf_rd_i);
			irq_reg  <= done || (irq_reg && !irq_clr_i);
			write_collision_flag_reg <= write_collision_flag_set || (write_collision_flag_reg && !write_collision_flag_clr_i);
			wake_reg <= done && irq_en_i;
		end
	end

	// ****************************************
	// Pins and status
	// ****************************************

	// SDO drives unless disabled, turned to input, or deselected.
	assign sdo_oe_o   = en && !sdo_dir_in_i &&
	                    (is_master || !ss_ctl || !ss_n_i);
	assign sdo_o      = sdo_reg;
	assign sck_oe_o   = en && is_master;
	assign sck_o      = sck_reg;
	assign rx_data_o  = buf_reg;
	assign irq_flag_o = irq_reg;
	assign wake_o     = wake_reg;
	assign ctrl_one_o = {write_collision_flag_reg, 1'b0, cfg_i.en, cfg_i.clock_idle_polarity, cfg_i.mode};
	assign status_o   = {cfg_i.input_sample_phase, cfg_i.cke, 5'h0, bf_reg};

	// ****************************************
	// Assertions
	// ****************************************

	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rstn_i);

	property p_done_bf;
		done |=> bf_reg && irq_reg;
	endproperty
	a_done_bf: assert property (p_done_bf)
		else $error("Completed byte did not set flags.");

	property p_buf_cap;
		done |=> buf_reg == $past(done_byte);
	endproperty
	a_buf_cap: assert property (p_buf_cap)
		else $error("Buffer did not take the received byte.");

	property p_write_collision_flag_set;
		write_collision_flag_set && !m_done |=> write_collision_flag_reg && $stable(state_reg);
	endproperty
	a_write_collision_flag_set: assert property (p_write_collision_flag_set)
		else $error("Busy write not flagged or not ignored.");

	property p_write_collision_flag_hold;
		write_collision_flag_reg && !write_collision_flag_clr_i |=> write_collision_flag_reg;
	endproperty
	a_write_collision_flag_hold: assert property (p_write_collision_flag_hold)
		else $error("Collision flag cleared by hardware.");

	property p_bf_clr;
		buf_rd_i && !done |=> !bf_reg;
	endproperty
	a_bf_clr: assert property (p_bf_clr)
		else $error("Buffer read did not clear full flag.");

	property p_mstart;
		wr_ok && is_master |=> state_reg == ST_SHIFT ##0 edge_reg == 5'h0;
	endproperty
	a_mstart: assert property (p_mstart)
		else $error("Master write did not start a byte.");

	property p_ss_tri;
		ss_ctl && ss_n_i |-> !sdo_oe_o ##1 shreg_reg == 8'h00;
	endproperty
	a_ss_tri: assert property (p_ss_tri)
		else $error("High SS did not release SDO and reset.");

	property p_sleep;
		sleep_i && state_reg == ST_SHIFT |=> $stable(edge_reg) && $stable(sck_reg);
	endproperty
	a_sleep: assert property (p_sleep)
		else $error("Master advanced while asleep.");

	property p_wake;
		done && irq_en_i |=> wake_o ##1 !wake_o;
	endproperty
	a_wake: assert property (p_wake)
		else $error("Completion did not wake for one cycle.");

	property p_div4;
		tick_m && !use_tmr && cfg_i.mode == `SPIMS_MODE_MDIV4 && !m_done
			##1 !sleep_i [*2] |-> tick_m && !$past(tick_m);
	endproperty
	a_div4: assert property (p_div4)
		else $error("Divide by four half period wrong.");

	c_mdone: cover property (m_done);
	c_sdone: cover property (s_done);
	c_write_collision_flag: cover property (write_collision_flag_set);
	c_ssabort: cover property (ss_ctl && ss_n_i && bits_reg != 3'h0);

endmodule
`default_nettype wire

// ===== common/spims_defs.svh
// Constants of the byte-wide serial port: mode codes, bit positions,
// reset values and clock divide counts.
// Assumes the includer compiles it once per unit; the guard allows more.
`ifndef SPIMS_DEFS_SVH
`define SPIMS_DEFS_SVH

// Port mode select codes.
`define SPIMS_MODE_MDIV4   4'h0
`define SPIMS_MODE_MDIV16  4'h1
`define SPIMS_MODE_MDIV64  4'h2
`define SPIMS_MODE_MTMR    4'h3
`define SPIMS_MODE_SLV_SS  4'h4
`define SPIMS_MODE_SLV     4'h5

// Bit positions in serial_control_one and serial_status.
`define SPIMS_C1_WRITE_COLLISION_FLAG      7
`define SPIMS_C1_EN        5
`define SPIMS_C1_CKP       4
`define SPIMS_ST_SMP       7
`define SPIMS_ST_CKE       6
`define SPIMS_ST_BF        0

// Reset values.
`define SPIMS_BYTE_RST     8'h00

// System clocks per SCK period for each divisor, and per half period.
`define SPIMS_DIV4         7'd4
`define SPIMS_DIV16        7'd16
`define SPIMS_DIV64        7'd64
`define SPIMS_HALF4        (`SPIMS_DIV4 >> 1)
`define SPIMS_HALF16       (`SPIMS_DIV16 >> 1)
`define SPIMS_HALF64       (`SPIMS_DIV64 >> 1)

// Terminal step after the 16 clock edges of one byte, and the index of the last slave bit.
`define SPIMS_LAST_STEP    5'd16
`define SPIMS_LAST_BIT     3'd7

`endif

// ===== common/spims_pkg.sv
// Types shared by the serial port design and its bench.
// Assumes nothing of its surroundings.
package spims_pkg;

	// Configuration held by software in the control and status bytes.
	typedef struct packed {
		logic       input_sample_phase;
		logic       cke;
		logic       en;
		logic       clock_idle_polarity;
		logic [3:0] mode;
	} spims_cfg_s;

	// Master transfer state.
	typedef enum logic {
		ST_IDLE  = 1'b0,
		ST_SHIFT = 1'b1
	} spims_state_e;

endpackage

// ===== tb/spims_slave_model.sv
// External SPI slave that faces the port while it is master.
// Assumes edge select clear: data moves on the leading SCK edge.
`timescale 1ns/10ps
`default_nettype none

module spims_slave_model (
	input  wire logic       sck_i,
	input  wire logic       mosi_i,
	input  wire logic       ckp_i,
	input  wire logic [7:0] tx_i,
	output logic            miso_o,
	output logic [7:0]      rx_o
);
	logic [7:0] sh     = 8'h00;
	logic [3:0] cnt    = 4'h0;
	logic       act    = 1'h0;
	logic       miso_q = 1'h0;
	logic [7:0] rx_q   = 8'h00;

	// One process owns each model output.
	assign miso_o = miso_q;
	assign rx_o   = rx_q;

	// Leading edge puts a bit out, trailing edge takes one in. A stray trailing
	// edge from a polarity change is ignored because no byte is open then.
	always @(sck_i) begin
		if (sck_i !== ckp_i) begin
			if (!act) begin
				act = 1'h1;
				cnt = 4'h0;
				sh  = tx_i;
			end
			miso_q = sh[7];
		end else if (act) begin
			rx_q = {rx_q[6:0], mosi_i};
			sh   = {sh[6:0], 1'h0};
			cnt  = cnt + 4'h1;
			if (cnt == 4'h8) begin
				act    = 1'h0;
				miso_q = ~miso_q; // No stale bit once the byte is over.
			end
		end
	end
endmodule

`default_nettype wire

// ===== tb/spims_port_tb.sv
// Self-checking bench of the serial port, master and slave roles.
// Assumes inputs are taken on rising clock edges; the bench drives on falling.
`timescale 1ns/10ps
`default_nettype none
`include "spims_defs.svh"
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin miscompares++; \
	$display("ERROR t=%0t got %h exp %h", $time, (a), (b)); end end

module spims_port_tb;
	import spims_pkg::*;
	logic       clk_sys_i = 1'h0;
	logic       rstn_i    = 1'h0;
	spims_cfg_s cfg       = '0;
	logic       wr = 1'h0, rd = 1'h0, wclr = 1'h0, iclr = 1'h0, ien = 1'h0, slp = 1'h0;
	logic       tmr = 1'h0, tmr_on = 1'h0, sdoin = 1'h0, b_sck = 1'h0, b_sdi = 1'h0;
	logic       ss_n = 1'h1, slv = 1'h0;
	logic [7:0] wdata = 8'h00, stx = 8'h00, srx, rxd, ctl, sts;
	logic [2:0] tc = 3'h0;
	logic       sck, sck_oe, sdo, sdo_oe, irq, wake, miso;
	int         miscompares = 0, total_checks = 0, wakes = 0;
	wire        sdi_pin = slv ? b_sdi : miso;

	always #5 clk_sys_i = ~clk_sys_i;

	// Timer pulse every fifth clock, and a tally of wake pulses.
	always @(negedge clk_sys_i) begin
		tc  <= (tc == 3'h4) ? 3'h0 : tc + 3'h1;
		tmr <= tmr_on && (tc == 3'h0);
	end
	always @(posedge clk_sys_i) begin
		if (wake === 1'h1)
			wakes++;
	end

	spims_port u_spims_port (
		.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .cfg_i(cfg), .buf_wr_i(wr),
		.buf_wdata_i(wdata), .buf_rd_i(rd), .write_collision_flag_clr_i(wclr), .irq_clr_i(iclr),
		.irq_en_i(ien), .sleep_i(slp), .tmr2_pulse_i(tmr), .sdo_dir_in_i(sdoin),
		.sck_i(b_sck), .sdi_i(sdi_pin), .ss_n_i(ss_n), .sck_o(sck), .sck_oe_o(sck_oe),
		.sdo_o(sdo), .sdo_oe_o(sdo_oe), .rx_data_o(rxd), .ctrl_one_o(ctl),
		.status_o(sts), .irq_flag_o(irq), .wake_o(wake));
	spims_slave_model u_spims_slave_model (.sck_i(sck), .mosi_i(sdo), .ckp_i(cfg.clock_idle_polarity),
		.tx_i(stx), .miso_o(miso), .rx_o(srx));

	// *****************************************
	// Bus cycles and shared helpers.
	// *****************************************
	task automatic tick(input int n);
		repeat (n) @(negedge clk_sys_i);
	endtask
	// The enable is dropped around every change, as a reconfiguration must be.
	task automatic set_cfg(input logic [3:0] m, input logic p);
		cfg.en = 1'h0;
		tick(2);
		cfg.mode = m;
		cfg.clock_idle_polarity = p;
		cfg.en = 1'h1;
		tick(2);
	endtask
	task automatic wr_buf(input logic [7:0] d);
		wr = 1'h1;
		wdata = d;
		tick(1);
		wr = 1'h0;
	endtask
	task automatic rd_clr;
		rd = 1'h1;
		iclr = 1'h1;
		tick(1);
		rd = 1'h0;
		iclr = 1'h0;
	endtask
	task automatic wait_irq(output int n);
		n = 0;
		while (irq !== 1'h1 && n < 3000) begin
			tick(1);
			n++;
		end
		`CHK(n < 3000, 1'h1)
	endtask
	task automatic master_xfer(input logic [7:0] d, input logic [7:0] s, output int n);
		stx = s;
		wr_buf(d);
		wait_irq(n);
		`CHK(rxd, s)
		`CHK(sts[`SPIMS_ST_BF], 1'h1)
		`CHK(sck, cfg.clock_idle_polarity)
	endtask
	task automatic slv_byte(input logic [7:0] d, input int nb, output logic [7:0] g);
		g = 8'h00;
		for (int i = 7; i > 7 - nb; i--) begin
			b_sdi = d[i];
			b_sck = 1'h1;
			tick(3);
			g[i] = sdo;
			b_sck = 1'h0;
			tick(3);
		end
	endtask

	// *****************************************
	// Scenarios.
	// *****************************************
	task automatic t_rates;
		int n;
		int h;
		for (int m = 0; m < 3; m++) begin
			h = 2 << (2 * m);
			set_cfg(m[3:0], 1'h0);
			master_xfer(8'hA5 ^ m[7:0], 8'h3C + m[7:0], n);
			`CHK(srx, 8'hA5 ^ m[7:0])
			`CHK(n >= 16 * h && n <= 18 * h, 1'h1)
			rd_clr;
			`CHK(sts[`SPIMS_ST_BF], 1'h0)
		end
	endtask
	task automatic t_collide;
		int n;
		stx = 8'h5A;
		wr_buf(8'h81);
		tick(4);
		wr_buf(8'h7E);
		`CHK(ctl[`SPIMS_C1_WRITE_COLLISION_FLAG], 1'h1)
		wait_irq(n);
		`CHK(srx, 8'h81)
		tick(20);
		`CHK(ctl[`SPIMS_C1_WRITE_COLLISION_FLAG], 1'h1)
		wclr = 1'h1;
		tick(1);
		wclr = 1'h0;
		`CHK(ctl[`SPIMS_C1_WRITE_COLLISION_FLAG], 1'h0)
		rd_clr;
	endtask
	// The second byte shifts while the first still waits unread.
	task automatic t_double;
		int n;
		master_xfer(8'h11, 8'hC6, n);
		iclr = 1'h1;
		tick(1);
		iclr = 1'h0;
		stx = 8'h9D;
		wr_buf(8'h22);
		tick(10);
		`CHK({rxd, sts[`SPIMS_ST_BF]}, 9'h18D)
		wait_irq(n);
		`CHK(rxd, 8'h9D)
		`CHK(srx, 8'h22)
		rd_clr;
	endtask
	task automatic t_timer;
		int n;
		set_cfg(4'h3, 1'h1);
		tmr_on = 1'h1;
		master_xfer(8'h5C, 8'hE1, n);
		`CHK(n >= 75 && n <= 95, 1'h1)
		`CHK(srx, 8'h5C)
		tmr_on = 1'h0;
		rd_clr;
	endtask
	task automatic t_sleep;
		int n;
		logic s;
		set_cfg(4'h2, 1'h0);
		`CHK(wakes, 0)
		ien = 1'h1;
		stx = 8'h66;
		wr_buf(8'h99);
		tick(100);
		slp = 1'h1;
		tick(1);
		s = sck;
		tick(300);
		`CHK({sck, irq}, {s, 1'h0})
		slp = 1'h0;
		wait_irq(n);
		`CHK({rxd, srx}, 16'h6699)
		tick(2);
		`CHK(wakes, 1)
		ien = 1'h0;
		rd_clr;
	endtask
	task automatic t_sdoin;
		int n;
		set_cfg(4'h0, 1'h0);
		sdoin = 1'h1;
		tick(1);
		`CHK(sdo_oe, 1'h0)
		master_xfer(8'hFF, 8'h4B, n);
		sdoin = 1'h0;
		rd_clr;
	endtask
	task automatic t_slave;
		logic [7:0] g;
		slv = 1'h1;
		set_cfg(4'h4, 1'h0);
		`CHK(sdo_oe, 1'h0)
		// The shifter is held clear while deselected, so load after select.
		ss_n = 1'h0;
		wr_buf(8'hC3);
		tick(1);
		`CHK(sdo_oe, 1'h1)
		slv_byte(8'h6E, 8, g);
		tick(2);
		`CHK({g, rxd, irq}, 17'h186DD)
		rd_clr;
		slv_byte(8'hFF, 3, g);
		ss_n = 1'h1;
		#1;
		`CHK(sdo_oe, 1'h0)
		tick(2);
		ss_n = 1'h0;
		ien = 1'h1;
		slp = 1'h1;
		tick(2);
		slv_byte(8'h35, 8, g);
		tick(2);
		`CHK({rxd, irq}, 9'h06B)
		`CHK(wakes, 2)
		slp = 1'h0;
		ien = 1'h0;
		cfg.en = 1'h0;
		#1;
		`CHK({sdo_oe, sck_oe}, 2'h0)
		slv = 1'h0;
		ss_n = 1'h1;
		rd_clr;
	endtask
	// Edge select with late sampling: the MSB stands before SCK first moves.
	task automatic t_phase;
		int n;
		slv = 1'h1;
		b_sdi = 1'h1;
		cfg.en = 1'h0;
		cfg.cke = 1'h1;
		cfg.input_sample_phase = 1'h1;
		set_cfg(4'h0, 1'h0);
		wr_buf(8'hB4);
		`CHK({sck, sdo}, 2'h1)
		wait_irq(n);
		`CHK(rxd, 8'hFF)
		`CHK(sts[`SPIMS_ST_SMP:`SPIMS_ST_CKE], 2'h3)
		cfg.en = 1'h0;
		cfg.cke = 1'h0;
		cfg.input_sample_phase = 1'h0;
		slv = 1'h0;
		b_sdi = 1'h0;
		rd_clr;
	endtask
	// A reset in mid-byte must leave no completion behind.
	task automatic t_abort;
		set_cfg(4'h0, 1'h0);
		wr_buf(8'h0F);
		tick(10);
		rstn_i = 1'h0;
		tick(2);
		`CHK({irq, sts, ctl[`SPIMS_C1_WRITE_COLLISION_FLAG]}, 10'h000)
		rstn_i = 1'h1;
		tick(80);
		`CHK(irq, 1'h0)
	endtask

	task automatic give_verdict;
		$display("checks %0d mismatches %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// Main sequence; reset values are looked at while reset still holds.
	initial begin
		tick(6);
		`CHK({ctl, sts, rxd, irq}, 25'h0)
		tick(6);
		rstn_i = 1'h1;
		tick(2);
		t_rates();
		t_collide();
		t_double();
		t_timer();
		t_sleep();
		t_sdoin();
		t_slave();
		t_phase();
		t_abort();
		give_verdict();
	end

	// The run needs about 3700 clocks; this limit leaves ample margin.
	initial begin
		repeat (20000) @(posedge clk_sys_i);
		miscompares++;
		give_verdict();
	end
endmodule

`default_nettype wire
